/* tb/wbps_array_model.sv */
/*
   Behavioural flash array behind the sequencer's program port; keeps the last word taken at each low address byte.
   Assumes the sequencer's default 26-bit word address and one shared clock.
*/
`timescale 1ns/100ps
`default_nettype none
module wbps_array_model (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Program port
   input  wire logic        prog_valid,
   output logic             prog_ready,
   input  wire logic [25:0] prog_addr,
   input  wire logic [15:0] program_data_word,
   output logic             array_busy
);
   logic [15:0] mem [256];
   int          n_words;
   // Ready alternates so the sequencer always meets stalls, never a free-running sink.
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n)
      begin
         prog_ready <= 1'b0;
         array_busy <= 1'b0;
         n_words    <= 0;
      end
      else
      begin
         prog_ready <= ~prog_ready;
         array_busy <= prog_valid && prog_ready;
         if (prog_valid && prog_ready)
         begin
            mem[prog_addr[7:0]] <= program_data_word;
            n_words             <= n_words + 1;
         end
      end
endmodule : wbps_array_model
`default_nettype wire

/* tb/wbps_sequencer_tb.sv */
/*
   Self-checking bench for the buffered program sequencer: full program, aborts, lock,
   suspend and address space cases. Assumes the array model and the package are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module wbps_sequencer_tb;
   localparam logic [25:0] SA = 26'h0030000;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wr_valid = 1'b0;
   logic [25:0] wr_addr = 26'h0;
   logic [15:0] wr_data = 16'h0;
   logic        space_ok = 1'b1;
   logic        sector_locked = 1'b0;
   logic        erase_suspended = 1'b0;
   logic        suspend_cmd = 1'b0;
   logic        resume_cmd = 1'b0;
   logic        clear_status_cmd = 1'b0;
   logic        abort_reset_cmd = 1'b0;
   logic        prog_valid, prog_ready, array_busy, ready_busy_output, program_fail_flag;
   logic        buffer_abort_flag, abort_indicator_poll_bit, timeout_fail_poll_bit, data_poll_bit;
   logic        program_suspended, return_erase_suspend;
   logic [25:0] prog_addr;
   logic [15:0] program_data_word;
   logic [7:0]  status_byte;
   int          n_mismatch = 0;
   int          n_compared = 0;
   always #50 core_clk = ~core_clk;
   wbps_sequencer u_wbps_sequencer (.core_clk, .rst_n, .wr_valid, .wr_addr, .wr_data, .space_ok,
      .sector_locked, .erase_suspended, .suspend_cmd, .resume_cmd, .clear_status_cmd, .abort_reset_cmd,
      .prog_valid, .prog_ready, .prog_addr, .program_data_word, .array_busy, .ready_busy_output,
      .program_fail_flag, .buffer_abort_flag, .abort_indicator_poll_bit, .timeout_fail_poll_bit,
      .data_poll_bit, .program_suspended, .return_erase_suspend, .status_byte);
   wbps_array_model u_wbps_array_model (.core_clk, .rst_n, .prog_valid, .prog_ready, .prog_addr,
      .program_data_word, .array_busy);
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [25:0] a, input logic [15:0] d);
      @(negedge core_clk);
      wr_valid = 1'b1;
      wr_addr  = a;
      wr_data  = d;
      @(negedge core_clk);
      wr_valid = 1'b0;
   endtask : wr
   task automatic pulse(ref logic s);
      @(negedge core_clk);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
   endtask : pulse
   // Sector writes use different offsets on purpose: only sector bits may be decoded.
   task automatic start(input logic [15:0] cnt);
      wr({15'h0, wbps_pkg::UNLOCK1_ADDR}, {8'h00, wbps_pkg::UNLOCK1_DATA});
      wr({15'h0, wbps_pkg::UNLOCK2_ADDR}, {8'h00, wbps_pkg::UNLOCK2_DATA});
      wr(SA + 26'h0123, wbps_pkg::CMD_BUF_LOAD);
      wr(SA + 26'h0f00, cnt);
   endtask : start
   task automatic load(input logic [25:0] a0, input int n);
      for (int i = 0; i < n; i++)
         wr(a0 + 26'(i), 16'h5a00 | 16'(i));
   endtask : load
   task automatic wait_rdy;
      int k;
      for (k = 0; k < 4000 && ready_busy_output !== 1'b1; k++)
         @(negedge core_clk);
      if (k == 4000)
      begin
         n_mismatch++;
         $display("[ERR] ready_busy_output never returned high");
         end_of_test;
      end
   endtask : wait_rdy
   initial
   begin
      repeat (12) @(negedge core_clk);
      rst_n = 1'b1;
      `CHK("status_byte", 8'h80, status_byte)
      start(16'h0001);
      load(SA + 26'h0110, 2);
      wr(SA + 26'h0007, wbps_pkg::CMD_CONFIRM);
      @(negedge core_clk);
      `CHK("ready_busy_output", 1'b0, ready_busy_output)
      `CHK("data_poll_bit", 1'b1, data_poll_bit)
      wait_rdy;
      `CHK("words", 256, u_wbps_array_model.n_words)
      `CHK("word10", 16'h5a00, u_wbps_array_model.mem[8'h10])
      `CHK("word11", 16'h5a01, u_wbps_array_model.mem[8'h11])
      `CHK("word00", wbps_pkg::ERASED_WORD, u_wbps_array_model.mem[8'h00])
      `CHK("data_poll_bit", 1'b0, data_poll_bit)
      `CHK("origin", 1'b0, return_erase_suspend)
      `CHK("fail", 1'b0, program_fail_flag)
      $display("full program test done");
      for (int t = 0; t < 4; t++)
      begin
         start(t == 0 ? 16'h0100 : (t == 1 ? 16'h0002 : 16'h0001));
         if (t == 1)
            load(SA + 26'h02fe, 3);
         if (t == 2)
            load(SA + 26'h0200, 2);
         if (t == 2)
            wr(SA, wbps_pkg::CMD_BUF_LOAD);
         if (t == 3)
            load(SA + 26'h10200, 1);
         `CHK("status_byte_4_3", 2'b11, status_byte[4:3])
         `CHK("abort_poll", 1'b1, abort_indicator_poll_bit)
         pulse(abort_reset_cmd);
         `CHK("abort", 1'b0, buffer_abort_flag)
         `CHK("fail", 1'b1, program_fail_flag)
         pulse(clear_status_cmd);
         `CHK("fail", 1'b0, program_fail_flag)
         $display("abort test %0d done", t);
      end
      sector_locked = 1'b1;
      start(16'h0000);
      sector_locked = 1'b0;
      load(SA + 26'h0400, 1);
      wr(SA, wbps_pkg::CMD_CONFIRM);
      wait_rdy;
      `CHK("fail", 1'b1, program_fail_flag)
      `CHK("timeout_poll", 1'b1, timeout_fail_poll_bit)
      `CHK("words", 256, u_wbps_array_model.n_words)
      pulse(clear_status_cmd);
      $display("locked sector test done");
      erase_suspended = 1'b1;
      start(16'h0000);
      erase_suspended = 1'b0;
      load(SA + 26'h0500, 1);
      wr(SA, wbps_pkg::CMD_CONFIRM);
      pulse(suspend_cmd);
      `CHK("suspended", 1'b1, program_suspended)
      `CHK("status_susp", 1'b1, status_byte[2])
      pulse(resume_cmd);
      wait_rdy;
      `CHK("origin", 1'b1, return_erase_suspend)
      `CHK("words", 512, u_wbps_array_model.n_words)
      $display("suspend test done");
      space_ok = 1'b0;
      start(16'h0000);
      load(SA + 26'h0600, 1);
      wr(SA, wbps_pkg::CMD_CONFIRM);
      space_ok = 1'b1;
      `CHK("ready_busy_output", 1'b1, ready_busy_output)
      `CHK("words", 512, u_wbps_array_model.n_words)
      $display("address space test done");
      end_of_test;
   end
endmodule : wbps_sequencer_tb
`default_nettype wire

/* verilog/wbps_fifo.sv */
/*
   Small synchronous FIFO built from flip-flops, valid and ready on both sides.
   Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module wbps_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data,
   // Level
   output logic                  empty
);

   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_ptr_q;
   logic [PW-1:0]    rd_ptr_q;
   logic [PW:0]      count_q;
   logic             push;
   logic             pop;

   assign in_ready  = (count_q != DEPTH[PW:0]);
   assign out_valid = (count_q != '0);
   assign empty     = (count_q == '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rd_ptr_q];

   always_ff @(posedge core_clk)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop)
         begin
            count_q <= count_q + 1'b1;
         end
         else if (pop && !push)
         begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule : wbps_fifo
`default_nettype wire

/* verilog/wbps_pkg.sv */
/*
   Constants, field positions and state type for the write buffer program sequencer.
   Assumes word addressing of the flash array with 16-bit data words.
*/
// Operation
// RL1: one buffered program covers one aligned 512-byte line
// RL2: short loads never cross into another line
// RL3: buffer preset to all ones at start
// RL4: only main array or secure overlay accepted
// RL5: first unlock writes AA at 555
// RL6: second unlock writes 55 at 2AA
// RL7: third write is 0025h inside target sector
// RL8: fourth write is count minus one, same sector
// RL9: first pair picks line; wrong sector aborts
// RL10: later pairs ascend and stay in line; code checks the line only, not the ascending order
// RL11: every load write is data, counter decrements
// RL12: write outside selected line aborts at once
// RL13: confirm 0029h at sector starts busy programming
// RL14: anything but confirm when expected aborts
// RL15: count value above 255 aborts
// RL16: abort sets fail bit 4, abort bit 3
// RL17: fail cleared by success or clear-status
// RL18: locked sector is never changed
// RL19: program suspend halts the embedded algorithm
// RL20: completion returns to the originating standby state
// RL21: abort poll bit high until abort reset; code also clears it on clear-status
// RL22: sector match decodes only sector bits
package wbps_pkg;

   localparam int          ADDR_W_DEF    = 26;
   localparam int          DATA_W        = 16;
   localparam int          SECT_LSB_DEF  = 16;
   localparam int          LINE_LSB      = 8;
   localparam int          LINE_WORDS    = 256;
   localparam int          FIFO_DEPTH    = 8;

   localparam int          UNLOCK_ADDR_W = 11;
   localparam logic [10:0] UNLOCK1_ADDR  = 11'h555;
   localparam logic [10:0] UNLOCK2_ADDR  = 11'h2aa;
   localparam logic [7:0]  UNLOCK1_DATA  = 8'haa;
   localparam logic [7:0]  UNLOCK2_DATA  = 8'h55;
   localparam logic [15:0] CMD_BUF_LOAD  = 16'h0025;
   localparam logic [15:0] CMD_CONFIRM   = 16'h0029;
   localparam logic [15:0] MAX_COUNT     = 16'h00ff;
   localparam logic [15:0] ERASED_WORD   = 16'hffff;

   localparam int          ST_READY_BIT  = 7;
   localparam int          ST_FAIL_BIT   = 4;
   localparam int          ST_ABORT_BIT  = 3;
   localparam int          ST_SUSP_BIT   = 2;
   localparam int          POLL_DATA_BIT = 7;

   typedef enum logic [2:0]
   {
      WBPS_IDLE,
      WBPS_UNLOCK1,
      WBPS_UNLOCK2,
      WBPS_COUNT,
      WBPS_LOAD,
      WBPS_CONFIRM,
      WBPS_PROGRAM,
      WBPS_ABORTED
   } wbps_state_t;

endpackage : wbps_pkg

/* verilog/wbps_sequencer.sv */
/*
   Buffered program command sequencer: unlock, load, count, line checks, abort status,
   and the embedded walk that streams the preset line buffer to the array port.
   Assumes host writes arrive as single-cycle strobes from bus logic on core_clk, and
   that the array port, lock lookup and overlay state are on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module wbps_sequencer #(
   parameter int ADDR_W   = wbps_pkg::ADDR_W_DEF,
   parameter int SECT_LSB = wbps_pkg::SECT_LSB_DEF
) (
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst_n,
   // Host write cycles
   input  wire logic                      wr_valid,
   input  wire logic [ADDR_W-1:0]         wr_addr,
   input  wire logic [15:0]               wr_data,
   // Decoded side commands and device state
   input  wire logic                      space_ok,
   input  wire logic                      sector_locked,
   input  wire logic                      erase_suspended,
   input  wire logic                      suspend_cmd,
   input  wire logic                      resume_cmd,
   input  wire logic                      clear_status_cmd,
   input  wire logic                      abort_reset_cmd,
   // Array program port
   output logic                           prog_valid,
   input  wire logic                      prog_ready,
   output logic      [ADDR_W-1:0]         prog_addr,
   output logic      [15:0]               program_data_word,
   input  wire logic                      array_busy,
   // Status
   output logic                           ready_busy_output,
   output logic                           program_fail_flag,
   output logic                           buffer_abort_flag,
   output logic                           abort_indicator_poll_bit,
   output logic                           timeout_fail_poll_bit,
   output logic                           data_poll_bit,
   output logic                           program_suspended,
   output logic                           return_erase_suspend,
   output logic      [7:0]                status_byte
);

   localparam int LW = wbps_pkg::LINE_LSB;
   localparam int FW = ADDR_W + wbps_pkg::DATA_W;

   wbps_pkg::wbps_state_t state_q;

   logic [ADDR_W-1:SECT_LSB] sector_select_address_q;
   logic [ADDR_W-1:LW]       buffer_line_location_q;
   logic [7:0]               word_count_minus_one_q;
   logic                     first_q;
   logic                     locked_q;
   logic                     origin_q;
   logic                     susp_q;
   logic                     fail_q;
   logic                     abort_q;
   logic [15:0]              last_data_q;
   logic [LW:0]              walk_idx_q;
   logic [15:0]              buf_q [wbps_pkg::LINE_WORDS];

   logic sect_hit;
   logic line_hit;
   logic ev_unlock1;
   logic ev_unlock2;
   logic ev_bufcmd;
   logic ev_count;
   logic ev_count_bad;
   logic ev_load;
   logic ev_load_bad;
   logic ev_confirm;
   logic ev_confirm_ok;
   logic abort_now;
   logic start_prog;
   logic lock_fail;
   logic walk_done;
   logic walk_push;
   logic fifo_in_ready;
   logic fifo_empty;
   logic prog_done;

   // Only the sector field is compared, so any address inside the sector is accepted.
   assign sect_hit = (wr_addr[ADDR_W-1:SECT_LSB] == sector_select_address_q); // RL22
   assign line_hit = (wr_addr[ADDR_W-1:LW] == buffer_line_location_q);

   // The first unlock write is ignored unless the main array or the secure overlay is active.
   assign ev_unlock1 = (state_q == wbps_pkg::WBPS_IDLE) && wr_valid && space_ok && // RL4
                       (wr_addr[10:0] == wbps_pkg::UNLOCK1_ADDR) &&
                       (wr_data[7:0] == wbps_pkg::UNLOCK1_DATA); // RL5
   assign ev_unlock2 = (state_q == wbps_pkg::WBPS_UNLOCK1) && wr_valid &&
                       (wr_addr[10:0] == wbps_pkg::UNLOCK2_ADDR) &&
                       (wr_data[7:0] == wbps_pkg::UNLOCK2_DATA); // RL6
   assign ev_bufcmd  = (state_q == wbps_pkg::WBPS_UNLOCK2) && wr_valid &&
                       (wr_data == wbps_pkg::CMD_BUF_LOAD); // RL7

   assign ev_count     = (state_q == wbps_pkg::WBPS_COUNT) && wr_valid;
   assign ev_count_bad = ev_count && (!sect_hit || (wr_data > wbps_pkg::MAX_COUNT)); // RL8 RL15

   // The first pair is checked against the sector, every later one against the line.
   assign ev_load     = (state_q == wbps_pkg::WBPS_LOAD) && wr_valid; // RL11
   assign ev_load_bad = ev_load && (first_q ? !sect_hit : !line_hit); // RL9 RL12

   assign ev_confirm    = (state_q == wbps_pkg::WBPS_CONFIRM) && wr_valid;
   assign ev_confirm_ok = ev_confirm && sect_hit && (wr_data == wbps_pkg::CMD_CONFIRM); // RL13

   assign abort_now  = ev_count_bad || ev_load_bad || (ev_confirm && !ev_confirm_ok); // RL14
   assign start_prog = ev_confirm_ok && !locked_q;
   assign lock_fail  = ev_confirm_ok && locked_q; // RL18

   assign walk_done = walk_idx_q[LW];
   assign walk_push = (state_q == wbps_pkg::WBPS_PROGRAM) && !susp_q && !walk_done; // RL19
   assign prog_done = (state_q == wbps_pkg::WBPS_PROGRAM) && walk_done && fifo_empty && !array_busy;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= wbps_pkg::WBPS_IDLE;
      end
      else
      begin
         case (state_q)
            wbps_pkg::WBPS_IDLE:
            begin
               if (ev_unlock1)
               begin
                  state_q <= wbps_pkg::WBPS_UNLOCK1;
               end
            end
            wbps_pkg::WBPS_UNLOCK1:
            begin
               if (wr_valid)
               begin
                  state_q <= ev_unlock2 ? wbps_pkg::WBPS_UNLOCK2 : wbps_pkg::WBPS_IDLE;
               end
            end
            wbps_pkg::WBPS_UNLOCK2:
            begin
               if (wr_valid)
               begin
                  state_q <= ev_bufcmd ? wbps_pkg::WBPS_COUNT : wbps_pkg::WBPS_IDLE;
               end
            end
            wbps_pkg::WBPS_COUNT:
            begin
               if (ev_count)
               begin
                  state_q <= ev_count_bad ? wbps_pkg::WBPS_ABORTED : wbps_pkg::WBPS_LOAD;
               end
            end
            wbps_pkg::WBPS_LOAD:
            begin
               if (ev_load_bad)
               begin
                  state_q <= wbps_pkg::WBPS_ABORTED; // RL12
               end
               else if (ev_load && (word_count_minus_one_q == 8'h00))
               begin
                  state_q <= wbps_pkg::WBPS_CONFIRM;
               end
            end
            wbps_pkg::WBPS_CONFIRM:
            begin
               if (abort_now)
               begin
                  state_q <= wbps_pkg::WBPS_ABORTED; // RL14
               end
               else if (start_prog)
               begin
                  state_q <= wbps_pkg::WBPS_PROGRAM; // RL13
               end
               else if (lock_fail)
               begin
                  state_q <= wbps_pkg::WBPS_IDLE; // RL18
               end
            end
            wbps_pkg::WBPS_PROGRAM:
            begin
               if (prog_done)
               begin
                  state_q <= wbps_pkg::WBPS_IDLE; // RL20
               end
            end
            wbps_pkg::WBPS_ABORTED:
            begin
               if (abort_reset_cmd)
               begin
                  state_q <= wbps_pkg::WBPS_IDLE; // RL21
               end
            end
            default:
            begin
               state_q <= wbps_pkg::WBPS_IDLE;
            end
         endcase
      end
   end

   // Origin of the sequence decides which standby state is shown after completion.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         origin_q <= 1'b0;
      end
      else if (ev_unlock1)
      begin
         origin_q <= erase_suspended; // RL20
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sector_select_address_q <= '0;
         locked_q                <= 1'b0;
      end
      else if (ev_bufcmd)
      begin
         sector_select_address_q <= wr_addr[ADDR_W-1:SECT_LSB];
         locked_q                <= sector_locked; // RL18
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         word_count_minus_one_q <= 8'h00;
         first_q                <= 1'b0;
      end
      else if (ev_count)
      begin
         word_count_minus_one_q <= wr_data[7:0];
         first_q                <= 1'b1;
      end
      else if (ev_load && !ev_load_bad)
      begin
         first_q <= 1'b0;
         if (word_count_minus_one_q != 8'h00)
         begin
            word_count_minus_one_q <= word_count_minus_one_q - 8'h01; // RL11
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buffer_line_location_q <= '0;
         last_data_q            <= 16'h0000;
      end
      else if (ev_load && !ev_load_bad)
      begin
         if (first_q)
         begin
            buffer_line_location_q <= wr_addr[ADDR_W-1:LW]; // RL1 RL9
         end
         last_data_q <= wr_data;
      end
   end

   // The whole line is preset, so unloaded words program as erased and keep array data.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < wbps_pkg::LINE_WORDS; i++)
         begin
            buf_q[i] <= wbps_pkg::ERASED_WORD;
         end
      end
      else if (ev_bufcmd)
      begin
         for (int i = 0; i < wbps_pkg::LINE_WORDS; i++)
         begin
            buf_q[i] <= wbps_pkg::ERASED_WORD; // RL3
         end
      end
      else if (ev_load && !ev_load_bad)
      begin
         buf_q[wr_addr[LW-1:0]] <= wr_data;
      end
   end

   // The walk advances only when the FIFO takes a word, so array back-pressure stalls it.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         walk_idx_q <= '0;
      end
      else if (start_prog)
      begin
         walk_idx_q <= '0;
      end
      else if (walk_push && fifo_in_ready)
      begin
         walk_idx_q <= walk_idx_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         susp_q <= 1'b0;
      end
      else if (state_q != wbps_pkg::WBPS_PROGRAM)
      begin
         susp_q <= 1'b0;
      end
      else if (suspend_cmd)
      begin
         susp_q <= 1'b1; // RL19
      end
      else if (resume_cmd)
      begin
         susp_q <= 1'b0;
      end
   end

   // Setting wins over clearing so an abort in a clear-status cycle is never lost.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fail_q <= 1'b0;
      end
      else if (abort_now || lock_fail)
      begin
         fail_q <= 1'b1; // RL16
      end
      else if (clear_status_cmd || prog_done)
      begin
         fail_q <= 1'b0; // RL17
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         abort_q <= 1'b0;
      end
      else if (abort_now)
      begin
         abort_q <= 1'b1; // RL16
      end
      else if (clear_status_cmd || (abort_reset_cmd && (state_q == wbps_pkg::WBPS_ABORTED)))
      begin
         abort_q <= 1'b0;
      end
   end

   wbps_fifo #(
      .WIDTH (FW),
      .DEPTH (wbps_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .in_valid  (walk_push),
      .in_ready  (fifo_in_ready),
      .in_data   ({buffer_line_location_q, walk_idx_q[LW-1:0], buf_q[walk_idx_q[LW-1:0]]}),
      .out_valid (prog_valid),
      .out_ready (prog_ready),
      .out_data  ({prog_addr, program_data_word}),
      .empty     (fifo_empty)
   );

   assign ready_busy_output        = (state_q != wbps_pkg::WBPS_PROGRAM);
   assign program_fail_flag        = fail_q;
   assign buffer_abort_flag        = abort_q;
   assign abort_indicator_poll_bit = abort_q; // RL21
   assign timeout_fail_poll_bit    = fail_q && !abort_q;
   assign data_poll_bit            = ready_busy_output ? last_data_q[wbps_pkg::POLL_DATA_BIT]
                                                       : !last_data_q[wbps_pkg::POLL_DATA_BIT];
   assign program_suspended        = susp_q;
   assign return_erase_suspend     = origin_q;

   always_comb
   begin
      status_byte                         = 8'h00;
      status_byte[wbps_pkg::ST_READY_BIT] = ready_busy_output;
      status_byte[wbps_pkg::ST_FAIL_BIT]  = fail_q;
      status_byte[wbps_pkg::ST_ABORT_BIT] = abort_q;
      status_byte[wbps_pkg::ST_SUSP_BIT]  = susp_q;
   end

   space_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
      (state_q == wbps_pkg::WBPS_IDLE) && wr_valid && !space_ok |=> state_q == wbps_pkg::WBPS_IDLE)
      else $error("unlock taken outside an allowed space");

   preset_ones_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL3
      ev_bufcmd |=> (buf_q[0] == wbps_pkg::ERASED_WORD) && (buf_q[wbps_pkg::LINE_WORDS-1] == wbps_pkg::ERASED_WORD))
      else $error("buffer not preset to ones");

   count_limit_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL15
      ev_count && (wr_data > wbps_pkg::MAX_COUNT) |=> (state_q == wbps_pkg::WBPS_ABORTED) && abort_q)
      else $error("oversized count not aborted");

   first_sector_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL9
      ev_load && first_q && !sect_hit |=> state_q == wbps_pkg::WBPS_ABORTED)
      else $error("first pair outside sector not aborted");

   line_escape_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL12
      ev_load && !first_q && !line_hit |=> (state_q == wbps_pkg::WBPS_ABORTED) && fail_q && abort_q)
      else $error("write outside line not aborted");

   count_step_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL11
      ev_load && !ev_load_bad && ($past(state_q) == wbps_pkg::WBPS_LOAD) && (word_count_minus_one_q != 8'h00)
      |=> (word_count_minus_one_q == $past(word_count_minus_one_q) - 8'h01) && (state_q == wbps_pkg::WBPS_LOAD))
      else $error("word counter did not step");

   confirm_abort_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL14 RL16
      ev_confirm && (wr_data != wbps_pkg::CMD_CONFIRM) |=> status_byte[4:3] == 2'b11)
      else $error("missing confirm did not set fail and abort");

   busy_start_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL13
      start_prog |=> !ready_busy_output ##1 (walk_idx_q == 9'h001) || !fifo_in_ready || susp_q)
      else $error("confirm did not start programming");

   locked_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL18
      lock_fail |=> ready_busy_output && fail_q && !abort_q)
      else $error("locked sector entered programming");

   suspend_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL19
      susp_q && !resume_cmd |=> $stable(walk_idx_q))
      else $error("walk advanced while suspended");

   fail_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL17
      (clear_status_cmd || prog_done) && !abort_now && !lock_fail |=> !fail_q)
      else $error("fail flag not cleared");

   return_state_a: assert property (@(posedge core_clk) disable iff (!rst_n) // RL20
      prog_done |=> (state_q == wbps_pkg::WBPS_IDLE) && (return_erase_suspend == $past(origin_q)))
      else $error("completion did not return to origin");

endmodule : wbps_sequencer
`default_nettype wire
